/* File: core/als_dark_pkg.sv */
// Constants, register map and carrier types for the dark-zone readout.
// Assumes a single 40 MHz clock and a synchronous active-low reset.
package als_dark_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 40_000_000;
    localparam int unsigned CONV_PERIOD_MS   = 80;
    localparam int unsigned CONV_PERIOD_CYC  = CLK_HZ / 1000 * CONV_PERIOD_MS;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_DARK_THR     = 8'h38;
    localparam logic [7:0] ADDR_DARK_HYS     = 8'h39;
    localparam logic [7:0] ADDR_RES1_LOW     = 8'h40;
    localparam logic [7:0] ADDR_RES1_HIGH    = 8'h41;
    localparam logic [7:0] RST_DARK_THR      = 8'h00;
    localparam logic [7:0] RST_DARK_HYS      = 8'h00;
    localparam logic [7:0] READ_UNMAPPED     = 8'h00;

    // ------------------------------------------------------------------
    // Result layout and scaling
    // ------------------------------------------------------------------
    localparam int unsigned RES_W            = 13;
    localparam int unsigned RES_LOW_MSB      = 7;
    localparam int unsigned RES_HIGH_W       = 5;
    localparam logic [12:0] RES_MAX          = 13'h1f40;
    localparam logic [12:0] RES_RST          = 13'h0000;
    localparam logic [2:0]  HIGH_RSVD        = 3'h0;
    localparam int unsigned RES_FULL_COUNT   = 8000;
    localparam int unsigned STEP_NA          = 540;
    localparam int unsigned CMP_W            = 40;
    localparam int unsigned FULL_SCALE_NA    = 1_000_000;

    // ------------------------------------------------------------------
    // Zones
    // ------------------------------------------------------------------
    localparam logic [2:0]  ZONE_INDOOR      = 3'h4;
    localparam logic [2:0]  ZONE_DARK        = 3'h5;

    // ------------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------------
    localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h2b; // Arbitrary value
    localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_ADDR   = 4'h1,
        ST_A_ACK  = 4'h3,
        ST_PTR    = 4'h2,
        ST_P_ACK  = 4'h6,
        ST_WDATA  = 4'h7,
        ST_W_ACK  = 4'h5,
        ST_RDATA  = 4'hc,
        ST_R_ACK  = 4'hd
    } i2c_state_t;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_t;

endpackage

/* File: core/i2c_reg_port.sv */
// Byte-wide I2C target engine with an auto-incrementing register pointer.
// Assumes pin inputs are asynchronous; read data comes back combinationally.
`timescale 1ns/1ps
module i2c_reg_port
    import als_dark_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_oe_o,
    output logic [7:0]      ptr_o,
    input  wire logic [7:0] rdata_i,
    output reg_wr_t         wr_o
);

    // ------------------------------------------------------------------
    // Pin synchronisers and bus conditions
    // ------------------------------------------------------------------
    logic [1:0] scl_s_r;
    logic [1:0] sda_s_r;
    logic       scl_d_r;
    logic       sda_d_r;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;

    // Two flops per pin, then one more for edge detection
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[0], scl_i};
            sda_s_r <= {sda_s_r[0], sda_i};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end

    // Edge and start/stop decode on synchronised levels
    assign scl_rise = scl_s_r[1] & ~scl_d_r;
    assign scl_fall = ~scl_s_r[1] & scl_d_r;
    assign start_c  = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
    assign stop_c   = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];

    // ------------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------------
    i2c_state_t state_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic       rw_r;
    logic       ack_ok_r;

    // Byte shifting, acknowledge and pointer handling
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state_r  <= ST_IDLE;
            cnt_r    <= 4'h0;
            sh_r     <= 8'h00;
            rw_r     <= 1'b0;
            ack_ok_r <= 1'b0;
            sda_oe_o <= 1'b0;
            ptr_o    <= 8'h00;
            wr_o     <= '0;
        end else begin
            wr_o.en <= 1'b0;
            if (start_c) begin
                state_r  <= ST_ADDR; // Repeated start keeps the pointer
                cnt_r    <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (stop_c) begin
                state_r  <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end else if (scl_rise) begin
                unique case (state_r)
                    ST_ADDR, ST_PTR, ST_WDATA: begin
                        sh_r  <= {sh_r[6:0], sda_s_r[1]};
                        cnt_r <= cnt_r + 4'h1;
                    end
                    ST_RDATA: cnt_r <= cnt_r + 4'h1;
                    ST_R_ACK: ack_ok_r <= ~sda_s_r[1];
                    default: ;
                endcase
            end else if (scl_fall) begin
                unique case (state_r)
                    ST_ADDR: if (cnt_r == BITS_PER_BYTE) begin
                        if (sh_r[7:1] == DEV_ADDR) begin
                            state_r  <= ST_A_ACK;
                            rw_r     <= sh_r[0];
                            sda_oe_o <= 1'b1;
                        end else begin
                            state_r  <= ST_IDLE;
                        end
                    end
                    ST_A_ACK: begin
                        cnt_r <= 4'h0;
                        if (rw_r) begin
                            state_r  <= ST_RDATA;
                            sh_r     <= rdata_i;
                            sda_oe_o <= ~rdata_i[7];
                        end else begin
                            state_r  <= ST_PTR;
                            sda_oe_o <= 1'b0;
                        end
                    end
                    ST_PTR: if (cnt_r == BITS_PER_BYTE) begin
                        state_r  <= ST_P_ACK;
                        ptr_o    <= sh_r;
                        sda_oe_o <= 1'b1;
                    end
                    ST_P_ACK: begin
                        state_r  <= ST_WDATA;
                        cnt_r    <= 4'h0;
                        sda_oe_o <= 1'b0;
                    end
                    ST_WDATA: if (cnt_r == BITS_PER_BYTE) begin
                        state_r  <= ST_W_ACK;
                        wr_o     <= '{en: 1'b1, addr: ptr_o, data: sh_r};
                        sda_oe_o <= 1'b1;
                    end
                    ST_W_ACK: begin
                        state_r  <= ST_WDATA;
                        ptr_o    <= ptr_o + 8'h01;
                        cnt_r    <= 4'h0;
                        sda_oe_o <= 1'b0;
                    end
                    ST_RDATA: begin
                        if (cnt_r == BITS_PER_BYTE) begin
                            state_r  <= ST_R_ACK;
                            ptr_o    <= ptr_o + 8'h01;
                            sda_oe_o <= 1'b0;
                        end else begin
                            sh_r     <= {sh_r[6:0], 1'b0};
                            sda_oe_o <= ~sh_r[6];
                        end
                    end
                    ST_R_ACK: begin
                        cnt_r <= 4'h0;
                        if (ack_ok_r) begin
                            state_r  <= ST_RDATA;
                            sh_r     <= rdata_i;
                            sda_oe_o <= ~rdata_i[7];
                        end else begin
                            state_r  <= ST_IDLE; // Host ended the read
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

endmodule // i2c_reg_port

/* File: core/als_dark_zone.sv */
// Dark-zone comparator and first light sensor result registers.
// Assumes conversion data and sensor enable come from logic on ref_clk_i.
//
// Summary of operation
// - Enter dark zone 5 when measured current falls below the threshold.
// - Threshold is an 8-bit code, 0.54 uA per step, 137.7 uA full.
// - Leave to indoor zone 4 when current exceeds threshold plus hysteresis.
// - Hysteresis is an 8-bit code on the same 0.54 uA scale.
// - Result refreshes every 80 ms, only while the sensor is enabled.
// - Low result byte holds result bits 7 to 0.
// - Low result byte is read-only; host writes do not alter it.
// - High result byte holds bits 12 to 8 in 4:0; bits 7:5 reserved.
// - Result equals high times 0x100 plus low, never above 0x1F40.
`timescale 1ns/1ps
module als_dark_zone
    import als_dark_pkg::*;
#(
    parameter int unsigned   CONV_CYCLES  = CONV_PERIOD_CYC,
    parameter int unsigned   SENSOR_FS_NA = FULL_SCALE_NA,
    parameter logic [6:0]    DEV_ADDR     = DEV_ADDR_DEFAULT
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rstn_i,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe_o,
    input  wire logic              sensor1_en_i,
    input  wire logic [RES_W-1:0]  conv_result_i,
    output logic [2:0]             zone_sel_o,
    output logic                   result_upd_o
);

    // ------------------------------------------------------------------
    // Serial register port
    // ------------------------------------------------------------------
    logic [7:0]      ptr;
    logic [7:0]      rdata;
    reg_wr_t         wr;
    logic            port_oe;

    i2c_reg_port #(
        .DEV_ADDR (DEV_ADDR)
    ) i2c_reg_port_inst (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .sda_oe_o  (port_oe),
        .ptr_o     (ptr),
        .rdata_i   (rdata),
        .wr_o      (wr)
    );

    // Open-drain data pin: only ever pulls low
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            sda_o    <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            sda_o    <= 1'b0;
            sda_oe_o <= port_oe;
        end
    end

    // ------------------------------------------------------------------
    // Writable threshold registers
    // ------------------------------------------------------------------
    logic [7:0] dark_zone_threshold_r;
    logic [7:0] dark_zone_hysteresis_r;

    // Only the two comparator codes accept writes
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            dark_zone_threshold_r  <= RST_DARK_THR;
            dark_zone_hysteresis_r <= RST_DARK_HYS;
        end else if (wr.en) begin
            if (wr.addr == ADDR_DARK_THR)
                dark_zone_threshold_r <= wr.data;
            if (wr.addr == ADDR_DARK_HYS)
                dark_zone_hysteresis_r <= wr.data;
        end
    end

    // ------------------------------------------------------------------
    // Conversion period divider
    // ------------------------------------------------------------------
    localparam int unsigned DIV_W = $clog2(CONV_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_CYCLES - 1);
    logic [DIV_W-1:0] div_r;
    logic             tick_r;

    // Counts only while the sensor is on; restarts when it is off
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i || !sensor1_en_i) begin
            div_r  <= '0;
            tick_r <= 1'b0;
        end else if (div_r == DIV_LAST) begin
            div_r  <= '0;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Result capture
    // ------------------------------------------------------------------
    logic [RES_W-1:0] sensor1_result_r;
    logic             eval_r;

    // Latch a clamped sample on each period tick; host writes never land
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            sensor1_result_r <= RES_RST;
            eval_r           <= 1'b0;
        end else begin
            eval_r <= tick_r && sensor1_en_i;
            if (tick_r && sensor1_en_i) begin
                sensor1_result_r <= (conv_result_i > RES_MAX) ?
                                    RES_MAX : conv_result_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    logic [7:0] sensor1_result_low_field;
    logic [7:0] sensor1_result_high_field;

    assign sensor1_result_low_field  =
        sensor1_result_r[RES_LOW_MSB:0];
    assign sensor1_result_high_field =
        {HIGH_RSVD, sensor1_result_r[RES_W-1:RES_LOW_MSB+1]};

    // Unmapped offsets read as zero
    always_comb begin
        unique case (ptr)
            ADDR_DARK_THR:  rdata = dark_zone_threshold_r;
            ADDR_DARK_HYS:  rdata = dark_zone_hysteresis_r;
            ADDR_RES1_LOW:  rdata = sensor1_result_low_field;
            ADDR_RES1_HIGH: rdata = sensor1_result_high_field;
            default:        rdata = READ_UNMAPPED;
        endcase
    end

    // ------------------------------------------------------------------
    // Zone comparator
    // ------------------------------------------------------------------
    // Both sides are scaled to nA x 8000 so no division is needed
    localparam logic [CMP_W-1:0] FS_K   = CMP_W'(SENSOR_FS_NA);
    localparam logic [CMP_W-1:0] STEP_K =
        CMP_W'(64'(STEP_NA) * 64'(RES_FULL_COUNT));
    logic [CMP_W-1:0] meas_k;
    logic [CMP_W-1:0] trip_k;
    logic [CMP_W-1:0] leave_k;
    logic [8:0]       leave_code;

    assign leave_code = {1'b0, dark_zone_threshold_r}
                      + {1'b0, dark_zone_hysteresis_r};
    assign meas_k  = CMP_W'(sensor1_result_r) * FS_K;
    assign trip_k  = CMP_W'(dark_zone_threshold_r) * STEP_K;
    assign leave_k = CMP_W'(leave_code) * STEP_K;

    // Zone moves only right after a fresh result
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            zone_sel_o   <= ZONE_INDOOR;
            result_upd_o <= 1'b0;
        end else begin
            result_upd_o <= eval_r;
            if (eval_r) begin
                if (zone_sel_o == ZONE_DARK) begin
                    if (meas_k > leave_k)
                        zone_sel_o <= ZONE_INDOOR;
                end else if (meas_k < trip_k) begin
                    zone_sel_o <= ZONE_DARK;
                end
            end
        end
    end

endmodule // als_dark_zone

/* File: verification/als_dark_zone_checker.sv */
// Concurrent checks on the dark-zone readout top-level ports.
// Assumes one clock domain; the divider length comes in through bind.
`timescale 1ns/1ps
module als_dark_zone_checker
    import als_dark_pkg::*;
#(
    parameter int unsigned CONV_CYCLES = CONV_PERIOD_CYC
) (
    input wire logic             ref_clk_i,
    input wire logic             rstn_i,
    input wire logic             scl_i,
    input wire logic             sda_i,
    input wire logic             sda_o,
    input wire logic             sda_oe_o,
    input wire logic             sensor1_en_i,
    input wire logic [RES_W-1:0] conv_result_i,
    input wire logic [2:0]       zone_sel_o,
    input wire logic             result_upd_o
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [31:0] gap_r;

    // Cycles since the last update while the sensor stays enabled
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i || !sensor1_en_i || result_upd_o) begin
            gap_r <= '0;
        end else begin
            gap_r <= gap_r + 32'h1;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    reset_state_a: assert property (disable iff (1'b0) !rstn_i |=>
        zone_sel_o == ZONE_INDOOR && !result_upd_o && !sda_oe_o)
        else $error("outputs not cleared by reset");
    zone_legal_a: assert property (
        zone_sel_o == ZONE_INDOOR || zone_sel_o == ZONE_DARK)
        else $error("zone outside indoor and dark");
    zone_hold_a: assert property (
        !$stable(zone_sel_o) |-> result_upd_o)
        else $error("zone moved without an update");
    upd_pulse_a: assert property (
        result_upd_o |=> !result_upd_o [*8])
        else $error("updates too close together");
    upd_period_a: assert property (
        gap_r <= CONV_CYCLES + 3)
        else $error("enabled sensor missed its refresh");
    upd_gated_a: assert property (
        !sensor1_en_i [*4] |-> !result_upd_o)
        else $error("update while sensor disabled");
    dark_keep_a: assert property (
        (conv_result_i == 13'h0000) [*4] ##0 zone_sel_o == ZONE_DARK
        |=> zone_sel_o == ZONE_DARK)
        else $error("left dark zone on zero current");
    bright_keep_a: assert property (
        (conv_result_i >= RES_MAX) [*4] ##0 zone_sel_o == ZONE_INDOOR
        |=> zone_sel_o == ZONE_INDOOR)
        else $error("entered dark zone at full scale");
    sda_drive_a: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    sda_change_a: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data pin moved while clock high");

    // Main scenarios reached
    cover property (zone_sel_o == ZONE_INDOOR ##1 zone_sel_o == ZONE_DARK);
    cover property (zone_sel_o == ZONE_DARK ##1 zone_sel_o == ZONE_INDOOR);
    cover property ($rose(sda_oe_o));
endmodule // als_dark_zone_checker

bind als_dark_zone als_dark_zone_checker #(
    .CONV_CYCLES(CONV_CYCLES)
) als_dark_zone_checker_inst (
    .ref_clk_i    (ref_clk_i),
    .rstn_i       (rstn_i),
    .scl_i        (scl_i),
    .sda_i        (sda_i),
    .sda_o        (sda_o),
    .sda_oe_o     (sda_oe_o),
    .sensor1_en_i (sensor1_en_i),
    .conv_result_i(conv_result_i),
    .zone_sel_o   (zone_sel_o),
    .result_upd_o (result_upd_o)
);

/* File: verification/i2c_host_model.sv */
// Host processor model: drives register cycles on the two-wire bus.
// Assumes a pulled-up data wire; a quarter bit lasts eight clocks.
`timescale 1ns/1ps
module i2c_host_model
    import als_dark_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
    input  wire logic ref_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_pull_o
);
    // Bus idles released, clock standing high
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    // Quarter bit, changed just after the clock edge
    task automatic qtr();
        repeat (8) @(posedge ref_clk_i);
        #1;
    endtask

    // One bit out; a released bit also samples the wire
    task automatic put_bit(input logic b, output logic s);
        sda_pull_o = ~b;
        qtr();
        scl_o = 1'b1;
        qtr();
        s = sda_i;
        qtr();
        scl_o = 1'b0;
        qtr();
    endtask

    // Start or repeated start
    task automatic start();
        sda_pull_o = 1'b0;
        qtr();
        scl_o = 1'b1;
        qtr();
        sda_pull_o = 1'b1;
        qtr();
        scl_o = 1'b0;
        qtr();
    endtask

    task automatic stop();
        sda_pull_o = 1'b1;
        qtr();
        scl_o = 1'b1;
        qtr();
        sda_pull_o = 1'b0;
        qtr();
    endtask

    // Byte out, then the acknowledge slot; a high slot flags a refusal
    task automatic send(input logic [7:0] b, inout logic nak);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], s);
        end
        put_bit(1'b1, s);
        nak = nak | s;
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [7:0] v,
                             output logic nak);
        nak = 1'b0;
        start();
        send({DEV_ADDR, 1'b0}, nak);
        send(a, nak);
        send(v, nak);
        stop();
    endtask

    // Two data bytes in one frame; the pointer steps between them
    task automatic write_two(input logic [7:0] a, input logic [7:0] v0,
                             input logic [7:0] v1, output logic nak);
        nak = 1'b0;
        start();
        send({DEV_ADDR, 1'b0}, nak);
        send(a, nak);
        send(v0, nak);
        send(v1, nak);
        stop();
    endtask

    // Address-only frame to a chosen target address
    task automatic probe(input logic [6:0] ad, output logic nak);
        nak = 1'b0;
        start();
        send({ad, 1'b0}, nak);
        stop();
    endtask

    // Two bytes read: acknowledge the first, refuse after the second
    task automatic read_two(input logic [7:0] a, output logic [15:0] d,
                            output logic nak);
        logic s;
        nak = 1'b0;
        start();
        send({DEV_ADDR, 1'b0}, nak);
        send(a, nak);
        start();
        send({DEV_ADDR, 1'b1}, nak);
        for (int i = 15; i >= 0; i--) begin
            put_bit(1'b1, d[i]);
            if (i == 8) begin
                put_bit(1'b0, s);
            end
        end
        put_bit(1'b1, s);
        stop();
    endtask

    // Pointer write, repeated start, one byte read then not-acknowledge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                            output logic nak);
        logic s;
        nak = 1'b0;
        start();
        send({DEV_ADDR, 1'b0}, nak);
        send(a, nak);
        start();
        send({DEV_ADDR, 1'b1}, nak);
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, d[i]);
        end
        put_bit(1'b1, s);
        stop();
    endtask
endmodule // i2c_host_model

/* File: verification/als_dark_zone_tb.sv */
// Self-checking bench for the dark-zone readout.
// Assumes the host model and a 16-cycle conversion divider.
`timescale 1ns/1ps
module als_dark_zone_tb;
    import als_dark_pkg::*;
    logic             ref_clk_i;
    logic             rstn_i;
    logic             en;
    logic [RES_W-1:0] conv;
    logic             scl;
    logic             pull;
    logic             sda_o;
    logic             oe;
    logic [2:0]       zone;
    logic             upd;
    wire              sda_w = ~(pull | oe);
    int               fails;
    int               tests_run;
    logic [7:0]       d;
    logic             nak;

    als_dark_zone #(.CONV_CYCLES(16)) als_dark_zone_inst (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_o(oe), .sensor1_en_i(en),
        .conv_result_i(conv), .zone_sel_o(zone), .result_upd_o(upd));
    i2c_host_model i2c_host_model_inst (
        .ref_clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl),
        .sda_pull_o(pull));

    // 40 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic tick();
        @(posedge ref_clk_i);
        #1;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Register access through the host model, acknowledge checked
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i2c_host_model_inst.read_reg(a, d, nak);
        check(d, e);
        check({7'h00, nak}, 8'h00);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        i2c_host_model_inst.write_reg(a, v, nak);
        check({7'h00, nak}, 8'h00);
    endtask

    // Bounded wait for n update pulses
    task automatic wait_upd(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                tick();
                k++;
            end while (upd !== 1'b1 && k < 200);
            if (upd !== 1'b1) begin
                fails++;
                wrap_up();
            end
        end
    endtask

    task automatic t_reset();
        rd(ADDR_DARK_THR, RST_DARK_THR);
        rd(ADDR_DARK_HYS, RST_DARK_HYS);
        check({5'h00, zone}, {5'h00, ZONE_INDOOR});
    endtask

    // Two-byte frames step the pointer; a foreign address is refused
    task automatic t_burst();
        logic [15:0] w;
        i2c_host_model_inst.write_two(ADDR_DARK_THR, 8'h21, 8'h43, nak);
        check({7'h00, nak}, 8'h00);
        i2c_host_model_inst.read_two(ADDR_DARK_THR, w, nak);
        check(w[15:8], 8'h21);
        check(w[7:0], 8'h43);
        check({7'h00, nak}, 8'h00);
        i2c_host_model_inst.probe(DEV_ADDR_DEFAULT ^ 7'h01, nak);
        check({7'h00, nak}, 8'h01);
    endtask

    // Trip 10 codes, hysteresis 5 codes; unmapped place reads zero
    task automatic t_regs();
        wr(ADDR_DARK_THR, 8'h0a);
        wr(ADDR_DARK_HYS, 8'h05);
        rd(ADDR_DARK_THR, 8'h0a);
        rd(ADDR_DARK_HYS, 8'h05);
        rd(8'h50, READ_UNMAPPED);
    endtask

    task automatic t_result();
        en = 1'b1;
        conv = 13'h1234;
        wait_upd(2);
        rd(ADDR_RES1_LOW, 8'h34);
        wr(ADDR_RES1_LOW, 8'hff);
        rd(ADDR_RES1_LOW, 8'h34);
        rd(ADDR_RES1_HIGH, 8'h12);
        conv = 13'h1fff;
        wait_upd(2);
        rd(ADDR_RES1_HIGH, 8'h1f);
        rd(ADDR_RES1_LOW, 8'h40);
    endtask

    // Trip below 43.2 counts, leave above 64.8 counts
    task automatic t_zone();
        logic [12:0] cv [5] = '{13'd44, 13'd43, 13'd0, 13'd64, 13'd65};
        logic [2:0]  ez [5] = '{ZONE_INDOOR, ZONE_DARK, ZONE_DARK,
                                ZONE_DARK, ZONE_INDOOR};
        for (int i = 0; i < 5; i++) begin
            conv = cv[i];
            wait_upd(2);
            check({5'h00, zone}, {5'h00, ez[i]});
        end
    endtask

    // Disabled sensor: no refresh, zone held despite dark input
    task automatic t_gate();
        int cnt;
        cnt = 0;
        conv = 13'h0000;
        en = 1'b0;
        repeat (4) tick();
        repeat (100) begin
            tick();
            if (upd === 1'b1) begin
                cnt++;
            end
        end
        check(8'(cnt), 8'h00);
        check({5'h00, zone}, {5'h00, ZONE_INDOOR});
    endtask

    // Reset in mid-run drops the dark zone and the written codes
    task automatic t_reset_mid();
        en = 1'b1;
        conv = 13'h0000;
        wait_upd(2);
        check({5'h00, zone}, {5'h00, ZONE_DARK});
        rstn_i = 1'b0;
        repeat (2) tick();
        rstn_i = 1'b1;
        repeat (2) tick();
        check({5'h00, zone}, {5'h00, ZONE_INDOOR});
        check({7'h00, upd}, 8'h00);
        rd(ADDR_DARK_THR, RST_DARK_THR);
        rd(ADDR_DARK_HYS, RST_DARK_HYS);
    endtask

    initial begin
        fails = 0;
        tests_run = 0;
        rstn_i = 1'b0;
        en = 1'b0;
        conv = '0;
        repeat (4) tick();
        rstn_i = 1'b1;
        repeat (4) tick();
        t_reset();
        t_burst();
        t_regs();
        t_result();
        t_zone();
        t_gate();
        t_reset_mid();
        wrap_up();
    end
endmodule // als_dark_zone_tb
